// >>> hdl/sysctl_pkg.sv
`default_nettype none

package sysctl_pkg;

    // ************************************************************
    // Bus geometry
    // ************************************************************
    localparam int          DATA_W          = 32;
    localparam int          REG_W           = 8;
    localparam int          IDX_W           = 6;
    localparam logic [1:0]  HTRANS_IDLE     = 2'h0;
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;
    localparam logic        HRESP_OKAY      = 1'h0;

    // ************************************************************
    // Register indices; the byte address is four times the index
    // ************************************************************
    localparam logic [IDX_W-1:0] IDX_SYSTEM_CONTROL  = 6'h09;
    localparam logic [IDX_W-1:0] IDX_RESERVED_SLOT   = 6'h0A;
    localparam logic [IDX_W-1:0] IDX_OFFSET_LOW      = 6'h0B;
    localparam logic [IDX_W-1:0] IDX_OFFSET_HIGH     = 6'h0C;
    localparam logic [IDX_W-1:0] IDX_MONITOR_STATUS  = 6'h1F;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [REG_W-1:0] RST_SYSTEM_CONTROL  = 8'h10;
    localparam logic [REG_W-1:0] RST_RESERVED_SLOT   = 8'h00;
    localparam logic [REG_W-1:0] RST_OFFSET_LOW      = 8'h00;
    localparam logic [REG_W-1:0] RST_OFFSET_HIGH     = 8'h00;

    // ************************************************************
    // System control field layout
    // ************************************************************
    localparam int          MON_MSB         = 7;
    localparam int          MON_LSB         = 5;
    localparam int          CAL_MSB         = 4;
    localparam int          CAL_LSB         = 3;
    localparam int          TIMEOUT_BIT     = 2;

    // ************************************************************
    // Encodings
    // ************************************************************
    typedef enum logic [2:0] {
        MON_OFF         = 3'h0,
        MON_MIDPOINT    = 3'h1,
        MON_TEMP        = 3'h2,
        MON_AVDD_QUARTER = 3'h3,
        MON_DVDD_QUARTER = 3'h4,
        MON_BURNOUT_LOW = 3'h5,
        MON_BURNOUT_MID = 3'h6,
        MON_BURNOUT_HIGH = 3'h7
    } monitor_select_t;

    typedef enum logic [1:0] {
        BURNOUT_0U2     = 2'h0,
        BURNOUT_1U      = 2'h1,
        BURNOUT_10U     = 2'h2
    } burnout_level_t;

    localparam logic [2:0]  GAIN_UNITY      = 3'h0;
    localparam logic [2:0]  GAIN_FOUR       = 3'h2;
    localparam logic [1:0]  AMP_ENABLED     = 2'h1;
    localparam logic [4:0]  CAL_SAMPLES_1   = 5'h01;
    localparam logic [4:0]  CAL_SAMPLES_4   = 5'h04;
    localparam logic [4:0]  CAL_SAMPLES_8   = 5'h08;
    localparam logic [4:0]  CAL_SAMPLES_16  = 5'h10;

    // Status register bit positions.
    localparam int          ST_GAIN_MSB     = 2;
    localparam int          ST_MUX_OPEN     = 3;
    localparam int          ST_AMP_FAULT    = 4;
    localparam int          ST_GAIN_HIGH    = 5;
    localparam int          ST_SUPPLY       = 6;

endpackage : sysctl_pkg

`default_nettype wire

// >>> hdl/monitor_if.sv
`default_nettype none

interface monitor_if;
    import sysctl_pkg::*;

    monitor_select_t    monitor_select;
    logic [1:0]         cal_code;
    logic [2:0]         programmed_gain;
    logic [1:0]         amp_enable_field;

    logic [2:0]         effective_gain;
    logic               amp_inputs_to_midpoint;
    logic               temp_sensor_select;
    logic               avdd_quarter_select;
    logic               dvdd_quarter_select;
    logic               burnout_enable;
    burnout_level_t     burnout_level;
    logic               input_mux_open;
    logic [4:0]         cal_average_count;
    logic               temp_amp_fault;
    logic               temp_gain_high;
    logic               supply_monitor_active;

    modport regs (
        output monitor_select, cal_code, programmed_gain, amp_enable_field,
        input  effective_gain, amp_inputs_to_midpoint, temp_sensor_select, avdd_quarter_select,
        input  dvdd_quarter_select, burnout_enable, burnout_level, input_mux_open,
        input  cal_average_count, temp_amp_fault, temp_gain_high, supply_monitor_active
    );

    modport decode (
        input  monitor_select, cal_code, programmed_gain, amp_enable_field,
        output effective_gain, amp_inputs_to_midpoint, temp_sensor_select, avdd_quarter_select,
        output dvdd_quarter_select, burnout_enable, burnout_level, input_mux_open,
        output cal_average_count, temp_amp_fault, temp_gain_high, supply_monitor_active
    );

endinterface : monitor_if

`default_nettype wire

// >>> hdl/monitor_decode.sv
`default_nettype none

module monitor_decode (
    input  wire logic   clk,
    input  wire logic   sys_rst,
    monitor_if.decode   mon
);
    import sysctl_pkg::*;

    // ************************************************************
    // Calibration sample count
    // ************************************************************
    function automatic logic [4:0] cal_samples(input logic [1:0] code);
        case (code)
            2'h0:    cal_samples = CAL_SAMPLES_1;
            2'h1:    cal_samples = CAL_SAMPLES_4;
            2'h2:    cal_samples = CAL_SAMPLES_8;
            default: cal_samples = CAL_SAMPLES_16;
        endcase
    endfunction : cal_samples

    wire logic is_mid     = (mon.monitor_select == MON_MIDPOINT);
    wire logic is_temp    = (mon.monitor_select == MON_TEMP);
    wire logic is_avdd    = (mon.monitor_select == MON_AVDD_QUARTER);
    wire logic is_dvdd    = (mon.monitor_select == MON_DVDD_QUARTER);
    wire logic is_supply  = is_avdd | is_dvdd;
    wire logic is_burnout = (mon.monitor_select == MON_BURNOUT_LOW) | (mon.monitor_select == MON_BURNOUT_MID)
                          | (mon.monitor_select == MON_BURNOUT_HIGH);

    // Supply monitors override the gain field; other modes keep it.
    wire logic [2:0] next_gain = is_supply ? GAIN_UNITY : mon.programmed_gain;  // [RULE_04] [RULE_05]

    wire burnout_level_t next_level = (mon.monitor_select == MON_BURNOUT_HIGH) ? BURNOUT_10U :
                                      (mon.monitor_select == MON_BURNOUT_MID)  ? BURNOUT_1U  :
                                                                                 BURNOUT_0U2;  // [RULE_06]

    // ************************************************************
    // Registered analog controls
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mon.effective_gain         <= GAIN_UNITY;
            mon.amp_inputs_to_midpoint <= 1'b0;
            mon.temp_sensor_select     <= 1'b0;
            mon.avdd_quarter_select    <= 1'b0;
            mon.dvdd_quarter_select    <= 1'b0;
            mon.burnout_enable         <= 1'b0;
            mon.burnout_level          <= BURNOUT_0U2;
            mon.input_mux_open         <= 1'b0;
            mon.cal_average_count      <= CAL_SAMPLES_8;
            mon.temp_amp_fault         <= 1'b0;
            mon.temp_gain_high         <= 1'b0;
            mon.supply_monitor_active  <= 1'b0;
        end else begin
            mon.effective_gain         <= next_gain;
            mon.amp_inputs_to_midpoint <= is_mid;                                 // [RULE_02]
            mon.temp_sensor_select     <= is_temp;                                // [RULE_03]
            mon.avdd_quarter_select    <= is_avdd;                                // [RULE_04]
            mon.dvdd_quarter_select    <= is_dvdd;                                // [RULE_04]
            mon.burnout_enable         <= is_burnout;                             // [RULE_06]
            mon.burnout_level          <= next_level;
            mon.input_mux_open         <= is_mid | is_temp | is_supply;           // [RULE_07]
            mon.cal_average_count      <= cal_samples(mon.cal_code);              // [RULE_09]
            mon.temp_amp_fault         <= is_temp & (mon.amp_enable_field != AMP_ENABLED);  // [RULE_03]
            mon.temp_gain_high         <= is_temp & (mon.programmed_gain > GAIN_FOUR);      // [RULE_08]
            mon.supply_monitor_active  <= is_supply;
        end
    end

endmodule : monitor_decode

`default_nettype wire

// >>> hdl/adc_system_control_registers.sv
//
// Overview of operation
// RULE_01: Monitor select lives in bits 7:5; zero disables monitoring and is default.
// RULE_02: Select 001 shorts amplifier inputs to midpoint, disconnects mux, keeps gain.
// RULE_03: Select 010 routes temperature sensor; amplifier must be enabled, gain kept.
// RULE_04: Select 011 measures quarter analog supply, 100 quarter digital supply, unity gain.
// RULE_05: Any supply monitor mode forces amplifier gain to unity regardless of field.
// RULE_06: Selects 101, 110, 111 enable burn-out sources at 0.2, 1, 10 uA.
// RULE_07: Midpoint, temperature and supply modes open every analog input switch.
// RULE_08: Host keeps gain at four or below while measuring temperature.
// RULE_09: Bits 4:3 choose calibration averaging of 1, 4, 8 or 16 samples.
// RULE_10: Bit 2 enables serial timeout; clear after reset.
// RULE_11: System control register sits at index 09 with reset value 10.
// RULE_12: Index 0A is reserved, read-only, reads 00.
// RULE_13: Index 0B holds low offset correction byte, read-write, resets to 00.
// RULE_14: Index 0C holds high offset byte, forming a 16-bit value with low.
// RULE_15: Host writes zeros to reserved control bits 1:0 and index 0A.
//
// Our own choice: the AHB-Lite slave port.
`default_nettype none

module adc_system_control_registers #(
    parameter int ADDR_W = 8
) (
    input  wire logic                           clk,
    input  wire logic                           sys_rst,
    input  wire logic                           hsel,
    input  wire logic [ADDR_W-1:0]              haddr,
    input  wire logic [1:0]                     htrans,
    input  wire logic                           hwrite,
    input  wire logic [2:0]                     hsize,
    input  wire logic [sysctl_pkg::DATA_W-1:0]  hwdata,
    input  wire logic                           hready,
    output logic      [sysctl_pkg::DATA_W-1:0]  hrdata,
    output logic                                hreadyout,
    output logic                                hresp,
    input  wire logic [2:0]                     programmed_gain,
    input  wire logic [1:0]                     amp_enable_field,
    output logic      [2:0]                     effective_gain,
    output logic                                amp_inputs_to_midpoint,
    output logic                                temp_sensor_select,
    output logic                                avdd_quarter_select,
    output logic                                dvdd_quarter_select,
    output logic                                burnout_enable,
    output logic      [1:0]                     burnout_level,
    output logic                                input_mux_open,
    output logic      [4:0]                     cal_average_count,
    output logic                                serial_timeout_enable,
    output logic      [15:0]                    offset_correction_value
);
    import sysctl_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The word index needs IDX_W + 2 address bits.
    if (ADDR_W < IDX_W + 2) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    // ************************************************************
    // Storage
    // ************************************************************
    logic [REG_W-1:0]   system_control;
    logic [REG_W-1:0]   offset_correction_low;
    logic [REG_W-1:0]   offset_correction_high;
    logic               wr_pending;
    logic [IDX_W-1:0]   wr_index;

    monitor_if mon ();

    // ************************************************************
    // Address phase decode
    // ************************************************************
    // Only whole words are written; address bits 1:0 select no lane.
    wire logic             addr_phase  = hsel & hready & (htrans == HTRANS_NONSEQ);
    wire logic             word_access = (hsize == HSIZE_WORD);
    wire logic [IDX_W-1:0] addr_index  = haddr[IDX_W+1:2];
    wire logic             upper_zero  = (haddr >> (IDX_W + 2)) == '0;
    wire logic             take_write  = addr_phase & hwrite & word_access & upper_zero;
    wire logic             take_read   = addr_phase & ~hwrite & upper_zero;

    // ************************************************************
    // Data phase write strobes
    // ************************************************************
    wire logic [REG_W-1:0] wr_byte = hwdata[REG_W-1:0];
    wire logic wr_sys  = wr_pending & (wr_index == IDX_SYSTEM_CONTROL);   // [RULE_11]
    wire logic wr_low  = wr_pending & (wr_index == IDX_OFFSET_LOW);       // [RULE_13]
    wire logic wr_high = wr_pending & (wr_index == IDX_OFFSET_HIGH);      // [RULE_14]

    // Reserved slot and status writes have no strobe and are dropped.
    wire logic [REG_W-1:0] next_system_control = wr_sys  ? wr_byte : system_control;
    wire logic [REG_W-1:0] next_offset_low     = wr_low  ? wr_byte : offset_correction_low;
    wire logic [REG_W-1:0] next_offset_high    = wr_high ? wr_byte : offset_correction_high;

    // ************************************************************
    // Read mux
    // ************************************************************
    // Read the next_ values so a read right after a write sees the new byte.
    wire logic [REG_W-1:0] status_word = {1'b0,
                                          mon.supply_monitor_active,
                                          mon.temp_gain_high,
                                          mon.temp_amp_fault,
                                          mon.input_mux_open,
                                          mon.effective_gain};
    wire logic [REG_W-1:0] read_byte =
        (addr_index == IDX_SYSTEM_CONTROL) ? next_system_control :
        (addr_index == IDX_RESERVED_SLOT)  ? RST_RESERVED_SLOT   :   // [RULE_12]
        (addr_index == IDX_OFFSET_LOW)     ? next_offset_low     :
        (addr_index == IDX_OFFSET_HIGH)    ? next_offset_high    :
        (addr_index == IDX_MONITOR_STATUS) ? status_word         :
                                             '0;
    wire logic [DATA_W-1:0] next_hrdata = take_read ? {{(DATA_W-REG_W){1'b0}}, read_byte} : '0;

    // ************************************************************
    // Bus sequencing
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_pending <= 1'b0;
            wr_index   <= '0;
            hrdata     <= '0;
        end else begin
            wr_pending <= take_write;
            wr_index   <= addr_index;
            hrdata     <= next_hrdata;
        end
    end

    // The slave never stalls and never errors.
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OKAY;

    // ************************************************************
    // Register file
    // ************************************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            system_control         <= RST_SYSTEM_CONTROL;   // [RULE_01] [RULE_10] [RULE_11]
            offset_correction_low  <= RST_OFFSET_LOW;       // [RULE_13]
            offset_correction_high <= RST_OFFSET_HIGH;      // [RULE_14]
        end else begin
            system_control         <= next_system_control;
            offset_correction_low  <= next_offset_low;
            offset_correction_high <= next_offset_high;
        end
    end

    // ************************************************************
    // Monitor decode
    // ************************************************************
    assign mon.monitor_select   = monitor_select_t'(system_control[MON_MSB:MON_LSB]);  // [RULE_01]
    assign mon.cal_code         = system_control[CAL_MSB:CAL_LSB];                     // [RULE_09]
    assign mon.programmed_gain  = programmed_gain;
    assign mon.amp_enable_field = amp_enable_field;

    monitor_decode u_decode (
        .clk     (clk),
        .sys_rst (sys_rst),
        .mon     (mon.decode)
    );

    assign effective_gain         = mon.effective_gain;
    assign amp_inputs_to_midpoint = mon.amp_inputs_to_midpoint;
    assign temp_sensor_select     = mon.temp_sensor_select;
    assign avdd_quarter_select    = mon.avdd_quarter_select;
    assign dvdd_quarter_select    = mon.dvdd_quarter_select;
    assign burnout_enable         = mon.burnout_enable;
    assign burnout_level          = mon.burnout_level;
    assign input_mux_open         = mon.input_mux_open;
    assign cal_average_count      = mon.cal_average_count;

    // ************************************************************
    // Direct register outputs
    // ************************************************************
    assign serial_timeout_enable   = system_control[TIMEOUT_BIT];                       // [RULE_10]
    assign offset_correction_value = {offset_correction_high, offset_correction_low};   // [RULE_14]

endmodule : adc_system_control_registers

`default_nettype wire

// >>> bench/adc_system_control_registers_props.sv
`default_nettype none

module adc_system_control_registers_props
    import sysctl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic                          clk,
    input wire logic                          sys_rst,
    input wire logic                          hsel,
    input wire logic [ADDR_W-1:0]             haddr,
    input wire logic [1:0]                    htrans,
    input wire logic                          hwrite,
    input wire logic [2:0]                    hsize,
    input wire logic [sysctl_pkg::DATA_W-1:0] hwdata,
    input wire logic                          hready,
    input wire logic [sysctl_pkg::DATA_W-1:0] hrdata,
    input wire logic [2:0]                    programmed_gain,
    input wire logic [2:0]                    effective_gain,
    input wire logic                          amp_inputs_to_midpoint,
    input wire logic                          temp_sensor_select,
    input wire logic                          avdd_quarter_select,
    input wire logic                          dvdd_quarter_select,
    input wire logic                          burnout_enable,
    input wire logic [1:0]                    burnout_level,
    input wire logic                          input_mux_open,
    input wire logic [4:0]                    cal_average_count,
    input wire logic                          serial_timeout_enable,
    input wire logic [15:0]                   offset_correction_value
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Decode of the bus and the mode outputs
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    wire logic       take   = hsel && hready && htrans == HTRANS_NONSEQ;
    wire logic [2:0] wmon   = hwdata[MON_MSB:MON_LSB];
    wire logic [1:0] wcal   = hwdata[CAL_MSB:CAL_LSB];
    wire logic       wto    = hwdata[TIMEOUT_BIT];
    wire logic [7:0] wbyte  = hwdata[7:0];
    wire logic       supply = avdd_quarter_select || dvdd_quarter_select;

    // The second cycle is the write's data phase.
    sequence wr_to(logic [IDX_W-1:0] idx);
        take && hwrite && hsize == HSIZE_WORD && haddr == ADDR_W'({idx, 2'b00}) ##1 1'b1;
    endsequence

    a_one_mode: assert property (
        $onehot0({amp_inputs_to_midpoint, temp_sensor_select, supply, burnout_enable}))
        else $error("more than one monitor mode active");
    a_mux_open_modes: assert property (
        input_mux_open == (amp_inputs_to_midpoint || temp_sensor_select || supply))
        else $error("input switches disagree with monitor mode");
    a_supply_unity: assert property (supply |-> effective_gain == GAIN_UNITY)
        else $error("gain not unity in supply monitor mode");
    a_gain_kept: assert property (
        !$past(sys_rst) && !supply |-> effective_gain == $past(programmed_gain))
        else $error("programmed gain not passed through");
    a_mode_decode: assert property (wr_to(IDX_SYSTEM_CONTROL) |=> ##1
        {amp_inputs_to_midpoint, temp_sensor_select, avdd_quarter_select, dvdd_quarter_select}
        == 4'(5'h10 >> $past(wmon, 2))) else $error("monitor mode decode wrong");
    a_burnout_step: assert property (wr_to(IDX_SYSTEM_CONTROL) |=> ##1
        burnout_enable == ($past(wmon, 2) > 3'h4) && (!burnout_enable || burnout_level == 2'($past(wmon, 2) - 3'h5)))
        else $error("burn-out current setting wrong");
    a_cal_count: assert property (wr_to(IDX_SYSTEM_CONTROL) |=> ##1
        cal_average_count == ($past(wcal, 2) == 2'h0 ? CAL_SAMPLES_1 : 5'(5'h02 << $past(wcal, 2))))
        else $error("calibration averaging count wrong");
    a_timeout_bit: assert property (wr_to(IDX_SYSTEM_CONTROL) |=> serial_timeout_enable == $past(wto))
        else $error("timeout enable not taken from write");
    a_offset_low: assert property (wr_to(IDX_OFFSET_LOW) |=> offset_correction_value[7:0] == $past(wbyte))
        else $error("low offset byte not updated");
    a_offset_high: assert property (wr_to(IDX_OFFSET_HIGH) |=> offset_correction_value[15:8] == $past(wbyte))
        else $error("high offset byte not updated");
    a_reserved_zero: assert property (take && !hwrite && haddr == ADDR_W'({IDX_RESERVED_SLOT, 2'b00}) |=>
        hrdata == '0) else $error("reserved slot read not zero");

endmodule : adc_system_control_registers_props

bind adc_system_control_registers adc_system_control_registers_props #(.ADDR_W(ADDR_W)) i_props (
    .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .programmed_gain,
    .effective_gain, .amp_inputs_to_midpoint, .temp_sensor_select, .avdd_quarter_select, .dvdd_quarter_select,
    .burnout_enable, .burnout_level, .input_mux_open, .cal_average_count, .serial_timeout_enable,
    .offset_correction_value
);

`default_nettype wire

// >>> bench/amp_config_model.sv
`default_nettype none

module amp_config_model
    import sysctl_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [2:0] gain_request,
    input  wire logic       temp_mode,
    output logic      [2:0] programmed_gain,
    output logic      [1:0] amp_enable_field
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // Amplifier settings as the host keeps them
    // ************************************************************
    // A gain above four would push the sensor signal out of the amplifier range.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            programmed_gain  <= GAIN_UNITY;
            amp_enable_field <= 2'h0;
        end else begin
            programmed_gain  <= (temp_mode && gain_request > GAIN_FOUR) ? GAIN_FOUR : gain_request;
            amp_enable_field <= AMP_ENABLED;
        end
    end

endmodule : amp_config_model

`default_nettype wire

// >>> bench/adc_system_control_registers_bench.sv
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end

module adc_system_control_registers_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sysctl_pkg::*;

    localparam logic [4:0] CAL_TAB [4] = '{CAL_SAMPLES_1, CAL_SAMPLES_4, CAL_SAMPLES_8, CAL_SAMPLES_16};

    logic        clk, sys_rst, hsel, hwrite, hreadyout, hresp, temp_mode;
    logic        mid, temp, avdd, dvdd, burn, mux_open, tmo;
    logic [7:0]  haddr;
    logic [1:0]  htrans, amp_enable_field, burnout_level;
    logic [2:0]  hsize, gain_request, programmed_gain, effective_gain;
    logic [31:0] hwdata, hrdata;
    logic [4:0]  cal_average_count;
    logic [15:0] offset_correction_value;
    int          err_total, checks_done;

    adc_system_control_registers i_dut (
        .clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .programmed_gain, .amp_enable_field, .effective_gain, .amp_inputs_to_midpoint(mid),
        .temp_sensor_select(temp), .avdd_quarter_select(avdd), .dvdd_quarter_select(dvdd), .burnout_enable(burn),
        .burnout_level, .input_mux_open(mux_open), .cal_average_count, .serial_timeout_enable(tmo),
        .offset_correction_value
    );

    amp_config_model i_amp (
        .clk, .sys_rst, .gain_request, .temp_mode, .programmed_gain, .amp_enable_field
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic results;
        if (err_total == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Sampled mid-cycle, where both have settled.
    task automatic data_phase(output logic [31:0] q);
        int n = 0;
        do begin
            @(negedge clk);
            q = hrdata;
            n++;
            if (n > 16) begin
                err_total++;
                results();
            end
        end while (hreadyout !== 1'b1);
        @(posedge clk);
    endtask : data_phase

    task automatic access(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= {idx, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        data_phase(q);
        htrans <= HTRANS_IDLE;
        hwdata <= d;
        data_phase(q);
    endtask : access

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [31:0] q;
        access(1'b1, idx, {24'h0, d}, q);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] e);
        logic [31:0] q;
        access(1'b0, idx, 32'h0, q);
        `CHK(q, {24'h0, e})
    endtask : rd

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        logic [7:0] d;
        logic [2:0] g;
        err_total = 0;
        checks_done = 0;
        sys_rst = 1'b1;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = HTRANS_IDLE;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        gain_request = 3'h5;
        temp_mode = 1'b0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        `CHK(cal_average_count, CAL_SAMPLES_8)
        `CHK({mid, temp, avdd, dvdd, burn, mux_open}, 6'h00)
        `CHK(tmo, 1'b0)
        `CHK(hresp, HRESP_OKAY)
        @(posedge clk);
        rd(IDX_SYSTEM_CONTROL, RST_SYSTEM_CONTROL);
        rd(IDX_RESERVED_SLOT, RST_RESERVED_SLOT);
        rd(IDX_OFFSET_LOW, RST_OFFSET_LOW);
        rd(IDX_OFFSET_HIGH, RST_OFFSET_HIGH);
        wr(IDX_RESERVED_SLOT, 8'hA5);
        rd(IDX_RESERVED_SLOT, 8'h00);
        rd(6'h05, 8'h00);
        wr(IDX_OFFSET_LOW, 8'h5A);
        rd(IDX_OFFSET_LOW, 8'h5A);
        wr(IDX_OFFSET_HIGH, 8'hC3);
        rd(IDX_OFFSET_HIGH, 8'hC3);
        `CHK(offset_correction_value, 16'hC35A)
        for (int m = 0; m < 8; m++) begin
            d = {3'(m), 2'(m), 1'(m), 2'b00};
            g = (m == 3 || m == 4) ? GAIN_UNITY : (m == 2) ? GAIN_FOUR : 3'h5;
            temp_mode <= (m == 2 || m == 3);
            wr(IDX_SYSTEM_CONTROL, d);
            rd(IDX_SYSTEM_CONTROL, d);
            `CHK({mid, temp, avdd, dvdd}, 4'(5'h10 >> m))
            `CHK(mux_open, 1'(m >= 1 && m <= 4))
            `CHK(effective_gain, g)
            `CHK(burn, 1'(m >= 5))
            if (m >= 5) `CHK(burnout_level, 2'(m - 5))
            `CHK(cal_average_count, CAL_TAB[m % 4])
            `CHK(tmo, d[TIMEOUT_BIT])
        end
        results();
    end

endmodule : adc_system_control_registers_bench

`default_nettype wire
